// ===== rtl/eft_pkg.sv
// Package for the E1 framer maintenance block: register map, field positions,
// reset values, timing constants and the structs that carry slot and status data.
// Assumes a 20 MHz core clock and a paged 5-bit-address microprocessor port.
package eft_pkg;

	// Clock rate and timer figures
	localparam int CLK_HZ = 20000000;
	localparam int T1_MS = 100; // Abnormal signal persistence
	localparam int T2_MS = 10; // Normal signal persistence
	localparam int T1_CYC = T1_MS * (CLK_HZ / 1000);
	localparam int T2_CYC = T2_MS * (CLK_HZ / 1000);

	// Line alarm bit counts
	localparam logic [10:0] AIS_SHORT_BITS = 11'd512;
	localparam logic [10:0] AIS_LONG_BITS = 11'd1024;
	localparam logic [9:0] AUX_BITS = 10'd512;
	localparam logic [7:0] LOS_ZERO_BITS = 8'd128; // More than 127 zeros
	localparam logic [6:0] LOS_WIN_BITS = 7'd127;
	localparam logic [6:0] LOS_MIN_ONES = 7'd16; // 12.5 percent of 127, rounded up

	// Pages
	localparam logic [7:0] PG_CTRL1 = 8'h01;
	localparam logic [7:0] PG_CTRL2 = 8'h02;
	localparam logic [7:0] PG_STAT3 = 8'h03;
	localparam logic [7:0] PG_STAT4 = 8'h04;
	localparam logic [7:0] PG_TSC_LO = 8'h07;
	localparam logic [7:0] PG_TSC_HI = 8'h08;
	localparam logic [7:0] PG_TXM_LO = 8'h0F;
	localparam logic [7:0] PG_TXM_HI = 8'h10;
	localparam logic [7:0] PG_RXM_LO = 8'h11;
	localparam logic [7:0] PG_RXM_HI = 8'h12;

	// Addresses within pages
	localparam logic [4:0] A_MODE = 5'h11;
	localparam logic [4:0] A_NAT_MASK = 5'h19;
	localparam logic [4:0] A_MASTER = 5'h1A;
	localparam logic [4:0] A_MASK0 = 5'h1B;
	localparam logic [4:0] A_MASK1 = 5'h1C;
	localparam logic [4:0] A_MASK2 = 5'h1D;
	localparam logic [4:0] A_MASK3 = 5'h1E;
	localparam logic [4:0] A_ERR_INS = 5'h10;
	localparam logic [4:0] A_ACCESS = 5'h13;
	localparam logic [4:0] A_SYNC_STAT = 5'h10;
	localparam logic [4:0] A_TIMER_STAT = 5'h12;
	localparam logic [4:0] A_PRBS_CNT = 5'h10;
	localparam logic [4:0] A_IVEC = 5'h12;
	localparam logic [4:0] A_ALARM_LATCH = 5'h1B;
	localparam logic [4:0] A_CRC_HI = 5'h1E;
	localparam logic [4:0] A_CRC_LO = 5'h1F;

	// Control bit positions
	localparam int B_AUTO_REMOTE_ALARM_DISABLE = 2;
	localparam int B_AUTO_MF_ALARM_DISABLE = 1;
	localparam int B_IRQ_ACKNOWLEDGE_BIT = 3;
	localparam int B_SPND = 4;
	localparam int B_AIS_LONG = 5;
	localparam int B_TEST_PATTERN_SELECT = 0;
	localparam int B_TX_FROM_MESSAGE_RAM = 7;
	localparam int B_REMOTE_SLOT_LOOP = 5;
	localparam int B_LOCAL_SLOT_LOOP = 4;
	localparam int B_TX_TEST_SELECT = 3;
	localparam int B_RX_TEST_SELECT = 2;

	// Reset values
	localparam logic [7:0] MASK0_RST = 8'hFF;
	localparam logic [7:0] MASK_OFF_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [14:0] PRBS_SEED = 15'h7FFF;

	// Milliwatt bytes, first byte in the top lane, bit 1 as MSB
	localparam logic [63:0] MW_SEQ = 64'h34212134B4A1A1B4;

	// One timeslot offered by the framer datapath
	typedef struct packed {
		logic [4:0] ts;
		logic [7:0] bp_tx; // Backplane transmit input byte
		logic [7:0] rx_line; // Received line byte
	} eft_slot_in_s;

	// One channel byte leaving the block
	typedef struct packed {
		logic [4:0] ts;
		logic [7:0] data;
	} eft_chan_byte_s;

	// Receive framer status
	typedef struct packed {
		logic frame_lost;
		logic multiframe_align_lost;
		logic crc_err;
		logic nfas_remote_bit;
		logic mfas_y_bit;
		logic ch16_all_ones;
		logic slip;
		logic cas_change;
	} eft_line_stat_s;

	// Transmit error injection controls
	typedef struct packed {
		logic inject_bipolar_violation;
		logic inject_crc_error;
		logic inject_frame_align_error;
		logic inject_nonalign_word_error;
		logic inject_payload_error;
		logic force_signal_loss;
	} eft_err_inject_s;

endpackage : eft_pkg

// ===== rtl/eft_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ns
module eft_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words
	logic [AW-1:0] wr_q, rd_q; // Pointers
	logic [AW:0] cnt_q, cnt_d; // Fill level
	logic push, pop;
	logic full_q, empty_q; // Registered flags

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign in_ready = ~full_q;
	assign out_valid = ~empty_q;
	assign out_data = mem[rd_q];

	// Next fill level
	always_comb begin
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Pointers and flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_d;
			full_q <= (cnt_d == (AW+1)'(DEPTH));
			empty_q <= (cnt_d == '0);
		end
	end

	// Word storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

endmodule : eft_fifo

// ===== rtl/eft_maint.sv
// E1 framer maintenance logic: CRC-4 error counter, error insertion, per-timeslot
// control with loops, PRBS and milliwatt, message RAMs, alarms, auto alarms, interrupts.
// Assumes slot and line bit inputs synchronous to core_clk; the line side drains tx words.
`timescale 1ns/1ns
module eft_maint import eft_pkg::*; #(
	parameter int T1_CYCLES = T1_CYC,
	parameter int T2_CYCLES = T2_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] cpu_page,
	input wire logic [4:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	input wire logic slot_valid,
	output logic slot_ready,
	input wire eft_slot_in_s slot,
	output logic tx_valid,
	input wire logic tx_ready,
	output eft_chan_byte_s tx_word,
	output logic bp_rx_valid,
	output eft_chan_byte_s bp_rx,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire eft_line_stat_s line_stat,
	output eft_err_inject_s err_inject,
	output logic tx_remote_alarm,
	output logic tx_mf_alarm,
	output logic irq_out,
	output logic irq_oe
);

	// PRBS generator: eight steps of x^15 + x^14 + 1, returns {state, byte}
	function automatic logic [22:0] eft_prbs_gen(input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] b;
		logic nb;
		st = s;
		b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			nb = st[14] ^ st[13];
			b[7-i] = nb;
			st = {st[13:0], nb};
		end
		return {st, b};
	endfunction : eft_prbs_gen

	// PRBS checker: self-synchronising, returns {state, error count}
	function automatic logic [18:0] eft_prbs_chk(input logic [14:0] s, input logic [7:0] d);
		logic [14:0] st;
		logic [3:0] e;
		st = s;
		e = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (d[7-i] != (st[14] ^ st[13])) begin
				e = e + 4'h1;
			end
			st = {st[13:0], d[7-i]};
		end
		return {st, e};
	endfunction : eft_prbs_chk

	// Register storage
	logic [7:0] mode_q, master_q, nat_mask_q, mask0_q, mask1_q, mask2_q, mask3_q;
	logic [7:0] errins_q, access_q; // Error insertion and access control
	logic [7:0] ts_ctrl_q [32]; // Per-timeslot control words
	logic [7:0] tx_msg_q [32]; // Transmit message RAM
	logic [7:0] rx_msg_q [32]; // Receive message RAM
	logic [9:0] crc_cnt_q; // CRC-4 error count
	logic [7:0] prbs_cnt_q; // PRBS error count
	logic [7:0] ivec_q, ivec_d; // Interrupt vector
	logic [7:0] alarm_latch_q; // Sticky alarm record
	logic [7:0] cpu_rdata_q;

	// Datapath state
	logic [14:0] gen_q, chk_q; // PRBS generator and checker
	logic [2:0] mw_idx_q; // Milliwatt byte index, one per frame
	logic bp_rx_valid_q;
	eft_chan_byte_s bp_rx_q;

	// Alarm detection state
	logic [10:0] ones_run_q;
	logic [9:0] alt_run_q;
	logic [7:0] zero_run_q;
	logic last_bit_q, los_q, los_win_q;
	logic [6:0] win_pos_q, win_ones_q;
	logic [$clog2(T1_CYCLES+1)-1:0] t1_cnt_q;
	logic [$clog2(T2_CYCLES+1)-1:0] t2_cnt_q;
	logic t1_q, t2_q;
	logic [7:0] prev_q; // Previous alarm levels for edge detection

	// Output flops
	logic tx_remote_alarm_q, tx_mf_alarm_q, irq_oe_q, irq_out_q;
	eft_err_inject_s err_inject_q;

	// Access decode
	logic wr_p1, wr_p2, rd_ivec, rd_alarm, irq_acknowledge_bit_tgl, slot_fire;
	logic [4:0] tsc_idx;
	assign wr_p1 = cpu_wr && cpu_page == PG_CTRL1;
	assign wr_p2 = cpu_wr && cpu_page == PG_CTRL2;
	assign rd_ivec = cpu_rd && cpu_page == PG_STAT4 && cpu_addr == A_IVEC;
	assign rd_alarm = cpu_rd && cpu_page == PG_STAT4 && cpu_addr == A_ALARM_LATCH;
	assign irq_acknowledge_bit_tgl = wr_p1 && cpu_addr == A_MASTER && cpu_wdata[B_IRQ_ACKNOWLEDGE_BIT] != master_q[B_IRQ_ACKNOWLEDGE_BIT];
	assign tsc_idx = {cpu_page[0] ^ 1'b1, cpu_addr[3:0]}; // Pages 07/0F/11 give index 0..15
	assign slot_fire = slot_valid & slot_ready;

	// Control registers on pages 01 and 02
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= CTRL_RST;
			master_q <= CTRL_RST;
			nat_mask_q <= MASK_OFF_RST;
			mask0_q <= MASK0_RST;
			mask1_q <= MASK_OFF_RST;
			mask2_q <= MASK_OFF_RST;
			mask3_q <= MASK_OFF_RST;
			errins_q <= CTRL_RST;
			access_q <= CTRL_RST;
		end else begin
			if (wr_p1) begin
				unique case (cpu_addr)
					A_MODE: mode_q <= cpu_wdata;
					A_MASTER: master_q <= cpu_wdata;
					A_NAT_MASK: nat_mask_q <= cpu_wdata;
					A_MASK0: mask0_q <= cpu_wdata;
					A_MASK1: mask1_q <= cpu_wdata;
					A_MASK2: mask2_q <= cpu_wdata;
					A_MASK3: mask3_q <= cpu_wdata;
					default: ;
				endcase
			end
			if (wr_p2 && cpu_addr == A_ERR_INS) begin
				errins_q <= cpu_wdata;
			end
			if (wr_p2 && cpu_addr == A_ACCESS) begin
				access_q <= cpu_wdata;
			end
		end
	end

	// Per-timeslot words, cleared by reset so every slot starts transparent
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				ts_ctrl_q[i] <= CTRL_RST;
			end
		end else if (cpu_wr && (cpu_page == PG_TSC_LO || cpu_page == PG_TSC_HI) && cpu_addr[4]) begin
			ts_ctrl_q[tsc_idx] <= cpu_wdata;
		end
	end

	// Transmit message RAM, processor written; low page holds slots 0..15
	always_ff @(posedge core_clk) begin
		if (cpu_wr && (cpu_page == PG_TXM_LO || cpu_page == PG_TXM_HI) && cpu_addr[4]) begin
			tx_msg_q[tsc_idx] <= cpu_wdata;
		end
	end

	// Slot datapath selections
	logic [7:0] ctl, tx_byte, bp_byte, mw_byte, prbs_byte;
	logic [14:0] gen_next, chk_next;
	logic [3:0] prbs_errs;
	logic test_pattern_select;
	always_comb begin
		test_pattern_select = access_q[B_TEST_PATTERN_SELECT];
		ctl = ts_ctrl_q[slot.ts];
		{gen_next, prbs_byte} = eft_prbs_gen(gen_q);
		{chk_next, prbs_errs} = eft_prbs_chk(chk_q, slot.rx_line);
		mw_byte = MW_SEQ[63 - 8 * int'(mw_idx_q) -: 8];
		tx_byte = ctl[B_TX_FROM_MESSAGE_RAM] ? tx_msg_q[slot.ts] : slot.bp_tx;
		if (ctl[B_REMOTE_SLOT_LOOP]) begin
			tx_byte = slot.rx_line;
		end
		if (ctl[B_TX_TEST_SELECT]) begin
			tx_byte = test_pattern_select ? mw_byte : prbs_byte;
		end
		bp_byte = slot.rx_line;
		if (ctl[B_LOCAL_SLOT_LOOP]) begin
			bp_byte = slot.bp_tx;
		end
		if (ctl[B_RX_TEST_SELECT] && test_pattern_select) begin
			bp_byte = mw_byte;
		end
	end

	// Transmit words through the four-word buffer; a full buffer stalls slot intake
	eft_fifo #(.WIDTH($bits(eft_chan_byte_s)), .DEPTH(4)) u_tx_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(slot_valid),
		.in_ready(slot_ready),
		.in_data({slot.ts, tx_byte}),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_word)
	);

	// Pattern sequencers and backplane output
	logic prbs_evt, prbs_ovf;
	logic [8:0] prbs_sum;
	assign prbs_sum = {1'b0, prbs_cnt_q} + {5'h00, prbs_errs};
	assign prbs_evt = slot_fire && ctl[B_RX_TEST_SELECT] && !test_pattern_select && prbs_errs != 4'h0;
	assign prbs_ovf = prbs_evt && prbs_sum[8];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gen_q <= PRBS_SEED;
			chk_q <= PRBS_SEED;
			mw_idx_q <= 3'h0;
			bp_rx_valid_q <= 1'b0;
			bp_rx_q <= '0;
		end else begin
			bp_rx_valid_q <= slot_fire;
			if (slot_fire) begin
				bp_rx_q <= {slot.ts, bp_byte};
				if (ctl[B_TX_TEST_SELECT] && !test_pattern_select) begin
					gen_q <= gen_next;
				end
				if (ctl[B_RX_TEST_SELECT] && !test_pattern_select) begin
					chk_q <= chk_next;
				end
				if (slot.ts == 5'h1F) begin
					mw_idx_q <= mw_idx_q + 3'h1;
				end
			end
		end
	end

	// Receive message RAM keeps the latest byte of each line channel
	always_ff @(posedge core_clk) begin
		if (slot_fire) begin
			rx_msg_q[slot.ts] <= slot.rx_line;
		end
	end

	// CRC-4 and PRBS error counters, processor presettable
	logic crc_evt, crc_ovf, crc_wr;
	// A CRC preset write wins over a count, so no event is raised then
	assign crc_wr = cpu_wr && cpu_page == PG_STAT4 && (cpu_addr == A_CRC_HI || cpu_addr == A_CRC_LO);
	assign crc_evt = line_stat.crc_err && !crc_wr;
	assign crc_ovf = crc_evt && crc_cnt_q == 10'h3FF;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crc_cnt_q <= 10'h000;
			prbs_cnt_q <= 8'h00;
		end else begin
			if (cpu_wr && cpu_page == PG_STAT4 && cpu_addr == A_CRC_HI) begin
				crc_cnt_q[9:8] <= cpu_wdata[1:0];
			end else if (cpu_wr && cpu_page == PG_STAT4 && cpu_addr == A_CRC_LO) begin
				crc_cnt_q[7:0] <= cpu_wdata;
			end else if (line_stat.crc_err) begin
				crc_cnt_q <= crc_cnt_q + 10'h001;
			end
			if (cpu_wr && cpu_page == PG_STAT4 && cpu_addr == A_PRBS_CNT) begin
				prbs_cnt_q <= cpu_wdata;
			end else if (prbs_evt) begin
				prbs_cnt_q <= prbs_sum[7:0];
			end
		end
	end

	// Line bit alarms: AIS, alternating pattern, loss of signal
	logic ais, aux;
	assign ais = ones_run_q >= (master_q[B_AIS_LONG] ? AIS_LONG_BITS : AIS_SHORT_BITS);
	assign aux = alt_run_q >= AUX_BITS;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ones_run_q <= 11'h000;
			alt_run_q <= 10'h000;
			zero_run_q <= 8'h00;
			last_bit_q <= 1'b0;
		end else if (rx_bit_valid) begin
			last_bit_q <= rx_bit;
			ones_run_q <= !rx_bit ? 11'h000 : (ones_run_q == AIS_LONG_BITS ? ones_run_q : ones_run_q + 11'h001);
			alt_run_q <= rx_bit == last_bit_q ? 10'h000 : (aux ? alt_run_q : alt_run_q + 10'h001);
			zero_run_q <= rx_bit ? 8'h00 : (zero_run_q == LOS_ZERO_BITS ? zero_run_q : zero_run_q + 8'h01);
		end
	end

	// Loss of signal declare and density-window release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			los_q <= 1'b0;
			los_win_q <= 1'b0;
			win_pos_q <= 7'h00;
			win_ones_q <= 7'h00;
		end else if (rx_bit_valid) begin
			if (!los_q) begin
				los_win_q <= 1'b0;
				if (!rx_bit && zero_run_q == LOS_ZERO_BITS - 8'h01) begin
					los_q <= 1'b1;
				end
			end else if (!los_win_q) begin
				if (rx_bit) begin
					los_win_q <= 1'b1; // Window opens on a pulse
					win_pos_q <= 7'h01;
					win_ones_q <= 7'h01;
				end
			end else if (win_pos_q == LOS_WIN_BITS - 7'h01) begin
				los_win_q <= 1'b0;
				if (win_ones_q + 7'(rx_bit) >= LOS_MIN_ONES) begin
					los_q <= 1'b0;
				end
			end else begin
				win_pos_q <= win_pos_q + 7'h01;
				win_ones_q <= win_ones_q + 7'(rx_bit);
			end
		end
	end

	// Abnormal and normal persistence timers
	logic abnormal;
	assign abnormal = los_q | ais | line_stat.frame_lost;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t1_cnt_q <= '0;
			t2_cnt_q <= '0;
			t1_q <= 1'b0;
			t2_q <= 1'b0;
		end else begin
			if (!abnormal) begin
				t1_cnt_q <= '0;
				t1_q <= 1'b0;
			end else if (t1_cnt_q == $bits(t1_cnt_q)'(T1_CYCLES - 1)) begin
				t1_q <= 1'b1;
			end else begin
				t1_cnt_q <= t1_cnt_q + 1'b1;
			end
			if (abnormal) begin
				t2_cnt_q <= '0;
				t2_q <= 1'b0;
			end else if (t2_cnt_q == $bits(t2_cnt_q)'(T2_CYCLES - 1)) begin
				t2_q <= 1'b1;
			end else begin
				t2_cnt_q <= t2_cnt_q + 1'b1;
			end
		end
	end

	// Alarm levels in latch order, and their rising edges
	logic [7:0] alarms, rise;
	assign alarms = {line_stat.nfas_remote_bit, ais, line_stat.ch16_all_ones, los_q,
		aux, line_stat.mfas_y_bit, t1_q, t2_q};
	assign rise = alarms & ~prev_q;

	// Alarm latch, cleared by read; a new alarm in the read cycle is kept
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alarm_latch_q <= 8'h00;
			prev_q <= 8'h00;
		end else begin
			prev_q <= alarms;
			alarm_latch_q <= (rd_alarm ? 8'h00 : alarm_latch_q) | alarms;
		end
	end

	// Per-category interrupt sources gated by their mask bits
	logic [7:0] cat;
	logic sync_rise, mf_rise, sync_prev_q, mf_prev_q;
	assign sync_rise = line_stat.frame_lost & ~sync_prev_q;
	assign mf_rise = line_stat.multiframe_align_lost & ~mf_prev_q;
	always_comb begin
		cat[7] = (sync_rise & mask0_q[7]) | (mf_rise & mask3_q[7]);
		cat[6] = (rise[7] & mask0_q[6]) | (rise[6] & mask0_q[5]) | (rise[5] & mask0_q[4])
			| (rise[4] & mask0_q[3]) | (rise[3] & mask2_q[1]);
		cat[5] = crc_evt & mask1_q[6];
		cat[4] = crc_ovf & mask2_q[6];
		cat[3] = (rise[1] & mask3_q[2]) | (rise[0] & mask3_q[1]);
		cat[2] = line_stat.slip & mask0_q[0];
		cat[1] = (prbs_ovf & nat_mask_q[6]) | (prbs_evt & nat_mask_q[5]);
		cat[0] = line_stat.cas_change & mask1_q[0];
		if (master_q[B_SPND]) begin
			cat = 8'h00; // Suspended
		end
		ivec_d = ((rd_ivec || irq_acknowledge_bit_tgl) ? 8'h00 : ivec_q) | cat;
	end

	// Interrupt vector and request pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ivec_q <= 8'h00;
			irq_oe_q <= 1'b0;
			irq_out_q <= 1'b0;
			sync_prev_q <= 1'b0;
			mf_prev_q <= 1'b0;
		end else begin
			sync_prev_q <= line_stat.frame_lost;
			mf_prev_q <= line_stat.multiframe_align_lost;
			ivec_q <= ivec_d;
			irq_oe_q <= |ivec_d;
			irq_out_q <= 1'b0; // Pin only ever pulled low
		end
	end

	// Automatic far-end alarms and error injection outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_remote_alarm_q <= 1'b0;
			tx_mf_alarm_q <= 1'b0;
			err_inject_q <= '0;
		end else begin
			tx_remote_alarm_q <= !mode_q[B_AUTO_REMOTE_ALARM_DISABLE] && line_stat.frame_lost;
			tx_mf_alarm_q <= !mode_q[B_AUTO_MF_ALARM_DISABLE] && line_stat.multiframe_align_lost;
			err_inject_q <= errins_q[5:0];
			if (errins_q[0]) begin
				err_inject_q.inject_bipolar_violation <= 1'b0;
			end
		end
	end

	// Processor read mux, answered one cycle after the read strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpu_rdata_q <= 8'h00;
		end else if (cpu_rd) begin
			cpu_rdata_q <= 8'h00; // Unmapped reads as zero
			unique case (cpu_page)
				PG_CTRL1: begin
					unique case (cpu_addr)
						A_MODE: cpu_rdata_q <= mode_q;
						A_MASTER: cpu_rdata_q <= master_q;
						A_NAT_MASK: cpu_rdata_q <= nat_mask_q;
						A_MASK0: cpu_rdata_q <= mask0_q;
						A_MASK1: cpu_rdata_q <= mask1_q;
						A_MASK2: cpu_rdata_q <= mask2_q;
						A_MASK3: cpu_rdata_q <= mask3_q;
						default: ;
					endcase
				end
				PG_CTRL2: begin
					if (cpu_addr == A_ERR_INS) cpu_rdata_q <= errins_q;
					if (cpu_addr == A_ACCESS) cpu_rdata_q <= access_q;
				end
				PG_STAT3: begin
					if (cpu_addr == A_SYNC_STAT) begin
						cpu_rdata_q <= {line_stat.frame_lost, line_stat.multiframe_align_lost, 6'h00};
					end
					if (cpu_addr == A_TIMER_STAT) cpu_rdata_q <= {6'h00, t1_q, t2_q};
				end
				PG_STAT4: begin
					unique case (cpu_addr)
						A_PRBS_CNT: cpu_rdata_q <= prbs_cnt_q;
						A_IVEC: cpu_rdata_q <= ivec_q;
						A_ALARM_LATCH: cpu_rdata_q <= alarm_latch_q;
						A_CRC_HI: cpu_rdata_q <= {6'h00, crc_cnt_q[9:8]};
						A_CRC_LO: cpu_rdata_q <= crc_cnt_q[7:0];
						default: ;
					endcase
				end
				PG_TSC_LO, PG_TSC_HI: if (cpu_addr[4]) cpu_rdata_q <= ts_ctrl_q[tsc_idx];
				PG_TXM_LO, PG_TXM_HI: if (cpu_addr[4]) cpu_rdata_q <= tx_msg_q[tsc_idx];
				PG_RXM_LO, PG_RXM_HI: if (cpu_addr[4]) cpu_rdata_q <= rx_msg_q[tsc_idx];
				default: ;
			endcase
		end
	end

	assign cpu_rdata = cpu_rdata_q;
	assign bp_rx_valid = bp_rx_valid_q;
	assign bp_rx = bp_rx_q;
	assign err_inject = err_inject_q;
	assign tx_remote_alarm = tx_remote_alarm_q;
	assign tx_mf_alarm = tx_mf_alarm_q;
	assign irq_out = irq_out_q;
	assign irq_oe = irq_oe_q;

endmodule : eft_maint

// ===== testbench/eft_maint_checker.sv
// Port checker for the maintenance block.
// Assumes it is bound to eft_maint and sees only its ports.
`timescale 1ns/1ns
module eft_maint_checker import eft_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] cpu_page,
	input wire logic [4:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic slot_valid,
	input wire logic slot_ready,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire eft_chan_byte_s tx_word,
	input wire logic bp_rx_valid,
	input wire eft_line_stat_s line_stat,
	input wire eft_err_inject_s err_inject,
	input wire logic tx_remote_alarm,
	input wire logic tx_mf_alarm,
	input wire logic irq_out,
	input wire logic irq_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Quiet read of the vector
	sequence vec_read;
		cpu_rd && cpu_page == PG_STAT4 && cpu_addr == A_IVEC && line_stat == '0;
	endsequence
	// No write in this or the last cycle
	sequence no_wr;
		!cpu_wr && !$past(cpu_wr);
	endsequence
	bp_pulse_a: assert property (slot_valid && slot_ready |=> bp_rx_valid) else $error("bp");
	rai_stop_a: assert property (!line_stat.frame_lost |=> !tx_remote_alarm) else $error("rai");
	y_stop_a: assert property (!line_stat.multiframe_align_lost |=> !tx_mf_alarm) else $error("y");
	irq_low_a: assert property (irq_oe |-> !irq_out) else $error("irq");
	vec_clear_a: assert property (vec_read |=> !irq_oe) else $error("clr");
	vec_hold_a: assert property (irq_oe && !cpu_rd ##0 no_wr |=> irq_oe) else $error("hold");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word)) else $error("tx");
	inj_hold_a: assert property (no_wr |=> $stable(err_inject)) else $error("inj");
endmodule : eft_maint_checker

// ===== testbench/eft_line_model.sv
// Framer datapath model: offers slots, drains transmit words.
// Assumes callers start a send just after a clock edge.
`timescale 1ns/1ns
module eft_line_model import eft_pkg::*; (
	input wire logic core_clk,
	output logic slot_valid,
	input wire logic slot_ready,
	output eft_slot_in_s slot,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire eft_chan_byte_s tx_word,
	input wire logic stall
);
	eft_chan_byte_s got[$]; // Words taken from the line side
	initial begin
		slot_valid = 0;
		slot = '0;
		tx_ready = 0;
	end
	// Drain unless stalled
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready) got.push_back(tx_word);
		tx_ready <= #1 !stall;
	end
	// One slot, held until taken, then the bus shows junk
	task automatic send(input logic [4:0] t, input logic [7:0] b, input logic [7:0] r);
		@(posedge core_clk);
		#1 slot_valid = 1;
		slot = '{t, b, r};
		do @(posedge core_clk); while (!slot_ready);
		#1 slot_valid = 0;
		slot = ~slot;
	endtask : send
endmodule : eft_line_model

// ===== testbench/test_eft_maint.sv
// Bench for the maintenance block: registers, slot paths, counters, alarms.
// Assumes the line model and the checker bound below.
`timescale 1ns/1ns
module test_eft_maint import eft_pkg::*;;
	logic core_clk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, rx_bit_valid = 0, rx_bit = 0, stall = 0;
	logic [7:0] cpu_page = 0, cpu_wdata = 0, cpu_rdata, last_bp[32];
	logic [4:0] cpu_addr = 0;
	logic slot_valid, slot_ready, tx_valid, tx_ready, bp_rx_valid, tx_remote_alarm, tx_mf_alarm, irq_out, irq_oe;
	eft_slot_in_s slot;
	eft_chan_byte_s tx_word, bp_rx;
	eft_line_stat_s line_stat = '0;
	eft_err_inject_s err_inject;
	int errors = 0, compares = 0, cyc = 0;
	eft_maint #(.T1_CYCLES(50), .T2_CYCLES(20)) dut (.*);
	eft_line_model m (.*);
	always #25 core_clk = ~core_clk;
	// Capture backplane bytes; cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (bp_rx_valid) last_bp[bp_rx.ts] = bp_rx.data;
		if (cyc == 10000) begin
			errors++;
			conclude();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] p, input logic [4:0] a, input logic [7:0] d);
		tick(1);
		{cpu_page, cpu_addr, cpu_wdata, cpu_wr} = {p, a, d, 1'b1};
		tick(1);
		cpu_wr = 0;
	endtask : wr
	// Register read compared under a mask
	task automatic rc(input logic [7:0] p, input logic [4:0] a, input logic [7:0] e, input logic [7:0] k);
		tick(1);
		{cpu_page, cpu_addr, cpu_rd} = {p, a, 1'b1};
		tick(1);
		cpu_rd = 0;
		chk(cpu_rdata & k, e);
	endtask : rc
	task automatic txchk(input logic [4:0] t, input logic [7:0] d);
		eft_chan_byte_s w;
		tick(3);
		w = m.got.size() > 0 ? m.got.pop_front() : 'x;
		chk({3'b0, w.ts}, {3'b0, t});
		chk(w.data, d);
	endtask : txchk
	task automatic pulse(input int n);
		line_stat[n] = 1;
		tick(1);
		line_stat[n] = 0;
		tick(1);
	endtask : pulse
	task automatic s_regs;
		rc(PG_CTRL1, A_MASK0, 8'hFF, 8'hFF);
		rc(PG_CTRL1, A_MASK1, 8'h00, 8'hFF);
		rc(8'h05, 5'h00, 8'h00, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			wr(PG_CTRL2, A_ERR_INS, 8'h01 << i);
			tick(1);
			chk({2'b0, err_inject}, 8'h01 << i);
		end
		wr(PG_CTRL2, A_ERR_INS, 8'h00);
	endtask : s_regs
	// Local loop, remote loop and message slots
	task automatic s_paths;
		wr(PG_TSC_LO, 5'h11, 8'h10);
		wr(PG_TSC_LO, 5'h12, 8'h20);
		wr(PG_TSC_LO, 5'h13, 8'h80);
		wr(PG_TXM_LO, 5'h13, 8'h5A);
		for (int t = 0; t < 4; t++) begin
			m.send(5'(t), 8'hC0 + 8'(t), 8'h30 + 8'(t));
			tick(3);
			chk(last_bp[t], t == 1 ? 8'hC1 : 8'h30 + 8'(t));
			txchk(5'(t), t == 2 ? 8'h32 : t == 3 ? 8'h5A : 8'hC0 + 8'(t));
		end
		rc(PG_RXM_LO, 5'h10, 8'h30, 8'hFF);
	endtask : s_paths
	task automatic s_mw;
		wr(PG_CTRL2, A_ACCESS, 8'h01);
		wr(PG_TSC_LO, 5'h14, 8'h0C);
		for (int i = 0; i < 8; i++) begin
			m.send(5'd4, 8'h00, 8'hEE);
			tick(3);
			chk(last_bp[4], MW_SEQ[63-8*i -: 8]);
			txchk(5'd4, MW_SEQ[63-8*i -: 8]);
			m.send(5'd31, 8'h00, 8'h00);
			txchk(5'd31, 8'h00);
		end
	endtask : s_mw
	// Transmit pattern looped into the checker one byte late, last byte inverted
	task automatic s_prbs;
		eft_chan_byte_s w;
		logic [7:0] g;
		wr(PG_CTRL2, A_ACCESS, 8'h00);
		wr(PG_TSC_LO, 5'h15, 8'h08);
		g = 8'h00;
		for (int i = 0; i < 4; i++) begin
			m.send(5'd5, 8'h00, i == 3 ? ~g : g);
			tick(3);
			w = m.got.pop_front();
			g = w.data;
			if (i == 0) wr(PG_TSC_LO, 5'h15, 8'h0C);
		end
		rc(PG_STAT4, A_PRBS_CNT, 8'h08, 8'hFF);
	endtask : s_prbs
	// Fill the transmit buffer with the line stalled
	task automatic s_fifo;
		stall = 1;
		repeat (4) m.send(5'd0, 8'hC0, 8'h00);
		tick(2);
		chk({7'b0, slot_ready}, 8'h00);
		stall = 0;
		repeat (4) txchk(5'd0, 8'hC0);
	endtask : s_fifo
	task automatic s_crc;
		wr(PG_CTRL1, A_MASK1, 8'h40);
		wr(PG_CTRL1, A_MASK2, 8'h40);
		repeat (3) pulse(5);
		tick(2);
		chk({7'b0, irq_oe}, 8'h01);
		rc(PG_STAT4, A_CRC_LO, 8'h03, 8'hFF);
		rc(PG_STAT4, A_IVEC, 8'h20, 8'hFF);
		chk({7'b0, irq_oe}, 8'h00);
		repeat (1020) pulse(5);
		rc(PG_STAT4, A_CRC_HI, 8'h03, 8'h03);
		rc(PG_STAT4, A_IVEC, 8'h20, 8'hFF);
		pulse(5);
		rc(PG_STAT4, A_CRC_LO, 8'h00, 8'hFF);
		rc(PG_STAT4, A_IVEC, 8'h30, 8'hFF);
	endtask : s_crc
	task automatic s_mask;
		wr(PG_CTRL1, A_MASK0, 8'h00);
		pulse(1);
		tick(3);
		chk({7'b0, irq_oe}, 8'h00);
		wr(PG_CTRL1, A_MASK0, 8'h01);
		pulse(1);
		tick(20);
		chk({7'b0, irq_oe}, 8'h01);
		wr(PG_CTRL1, A_MASTER, 8'h08);
		wr(PG_CTRL1, A_MASTER, 8'h00);
		chk({7'b0, irq_oe}, 8'h00);
	endtask : s_mask
	task automatic s_alarm;
		pulse(4);
		rc(PG_STAT4, A_ALARM_LATCH, 8'h80, 8'h80);
		rc(PG_STAT4, A_ALARM_LATCH, 8'h00, 8'h80);
		line_stat[7:6] = 2'b11;
		tick(3);
		chk({6'b0, tx_remote_alarm, tx_mf_alarm}, 8'h03);
		wr(PG_CTRL1, A_MODE, 8'h06);
		tick(2);
		chk({6'b0, tx_remote_alarm, tx_mf_alarm}, 8'h00);
	endtask : s_alarm
	task automatic bits(input int n, input logic b);
		rx_bit = b;
		rx_bit_valid = 1;
		tick(n);
		rx_bit_valid = 0;
	endtask : bits
	// All ones, then a long zero run, with frame loss still standing
	task automatic s_line;
		bits(520, 1'b1);
		rc(PG_STAT4, A_ALARM_LATCH, 8'h40, 8'h40);
		bits(130, 1'b0);
		rc(PG_STAT4, A_ALARM_LATCH, 8'h10, 8'h10);
		rc(PG_STAT3, A_TIMER_STAT, 8'h02, 8'h03);
	endtask : s_line
	task automatic conclude;
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		tick(5);
		rst = 0;
		s_regs();
		s_paths();
		s_mw();
		s_prbs();
		s_fifo();
		s_crc();
		s_mask();
		s_alarm();
		s_line();
		conclude();
	end
endmodule : test_eft_maint
bind eft_maint eft_maint_checker chk_i (.*);
